// file: design/pmr_pkg.sv
package pmr_pkg;
  localparam int MODE_W = 8;
  localparam int WORD_W = 20;
  // mode register bit positions
  localparam int MB_READBACK = 1;
  localparam int MB_VCO = 2;
  localparam int MB_PDOWN = 3;
  localparam int MB_CLOAD = 4;
  localparam int MB_MODULUS_SELECT = 5;
  localparam int MB_REF = 6;
  localparam logic [7:0] MODE_RST = 8'h00;
  // erased cells read as ones, since a write can only clear bits
  localparam logic [19:0] STORE_RST = 20'hfffff;
  localparam logic [19:0] WORD_RST = 20'h00000;
  // link line index within the device synchroniser vector
  localparam int LK_CLK = 0;
  localparam int LK_DATA = 1;
  localparam int LK_SWR = 2;
  localparam int LK_MWR = 3;
  localparam int LK_SEL = 4;
  localparam int LK_LOAD = 5;
  localparam int LK_MEN = 6;
  localparam int LK_ERASE = 7;
  localparam int LK_WRITE = 8;
  localparam int LK_N = 9;
  // controller register map (byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_WORD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_READBACK = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_MODE_OK = 1;
  localparam int ST_EN = 2;
  // timing
  localparam int CLK_NS = 25;
  localparam int SCLK_HALF_NS = 250;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_MS = 25;
  localparam int PULSE_CYC = (PULSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int GAP_MS = 100;
  localparam int GAP_CYC = (GAP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    OP_NONE, OP_MODE, OP_WORD, OP_ERASE, OP_WRITE, OP_READBACK
  } pmr_op_t;
  typedef enum logic [2:0] {
    HS_IDLE, HS_LO, HS_HI, HS_SETUP, HS_PULSE, HS_FINISH, HS_GAP
  } pmr_host_st_t;
endpackage

// file: design/pmr_link_if.sv
`timescale 1ns/1ps
interface pmr_link_if;
  logic ser_clk;
  logic ser_data;
  logic sec_wr;
  logic mode_wr;
  logic store_select;
  logic store_load;
  logic mode_enable_n;
  logic erase_pulse;
  logic write_pulse;
  logic serial_out;
  modport dev (
    input ser_clk, ser_data, sec_wr, mode_wr, store_select, store_load,
    input mode_enable_n, erase_pulse, write_pulse,
    output serial_out
  );
  modport prog (
    output ser_clk, ser_data, sec_wr, mode_wr, store_select, store_load,
    output mode_enable_n, erase_pulse, write_pulse,
    input serial_out
  );
endinterface

// file: design/pmr_sync.sv
`timescale 1ns/1ps
module pmr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } pmr_sync_st_t;
  pmr_sync_st_t st_ff;
  pmr_sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // edges look only at the second and third stage
  assign level_o = st_ff.s2;
  assign rise_o = st_ff.s2 & ~st_ff.s3;
  assign fall_o = ~st_ff.s2 & st_ff.s3;
endmodule // pmr_sync

// file: design/pmr_device.sv
`timescale 1ns/1ps
module pmr_device (
  input wire logic clk_i,
  input wire logic rst_i,
  pmr_link_if.dev link,
  input wire logic divided_vco_i,
  input wire logic modulus_select_i,
  input wire logic divided_reference_i,
  input wire logic reload_i,
  output logic [pmr_pkg::WORD_W-1:0] counter_word_o,
  output logic counter_load_o,
  output logic power_down_o,
  output logic [pmr_pkg::WORD_W-1:0] store_o
);
  typedef struct packed {
    logic [pmr_pkg::MODE_W-1:0] mode_sh;
    logic [pmr_pkg::MODE_W-1:0] mode_buf;
    logic [pmr_pkg::WORD_W-1:0] staging;
    logic [pmr_pkg::WORD_W-1:0] store;
    logic [pmr_pkg::WORD_W-1:0] word;
    logic dout;
    logic pdown;
    logic cload;
  } pmr_dev_st_t;
  pmr_dev_st_t st_ff;
  pmr_dev_st_t nxt_st;

  logic [pmr_pkg::LK_N-1:0] raw;
  logic [pmr_pkg::LK_N-1:0] lvl;
  logic [pmr_pkg::LK_N-1:0] rise;
  logic [pmr_pkg::LK_N-1:0] fall;
  logic [pmr_pkg::MODE_W-1:0] eff;
  logic shift_mode;
  logic shift_stage;
  logic copy_store;
  logic pd;

  // every link line, the serial clock included, is sampled on clk_i
  assign raw[pmr_pkg::LK_CLK] = link.ser_clk;
  assign raw[pmr_pkg::LK_DATA] = link.ser_data;
  assign raw[pmr_pkg::LK_SWR] = link.sec_wr;
  assign raw[pmr_pkg::LK_MWR] = link.mode_wr;
  assign raw[pmr_pkg::LK_SEL] = link.store_select;
  assign raw[pmr_pkg::LK_LOAD] = link.store_load;
  assign raw[pmr_pkg::LK_MEN] = link.mode_enable_n;
  assign raw[pmr_pkg::LK_ERASE] = link.erase_pulse;
  assign raw[pmr_pkg::LK_WRITE] = link.write_pulse;

  pmr_sync #(
    .W(pmr_pkg::LK_N)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(raw),
    .level_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  always_comb begin
    nxt_st = st_ff;
    // buffered copy only counts while enable is low
    eff = lvl[pmr_pkg::LK_MEN] ? '0 : st_ff.mode_buf;
    pd = eff[pmr_pkg::MB_PDOWN];
    // store load overrides the mode strobe when choosing the target
    shift_mode = rise[pmr_pkg::LK_CLK] & lvl[pmr_pkg::LK_MWR] & ~lvl[pmr_pkg::LK_LOAD];
    shift_stage = rise[pmr_pkg::LK_CLK] & (lvl[pmr_pkg::LK_LOAD] |
                  (eff[pmr_pkg::MB_READBACK] & ~lvl[pmr_pkg::LK_MWR]));
    // store to staging: select rises with load low, or load falls with select high
    copy_store = (rise[pmr_pkg::LK_SEL] & ~lvl[pmr_pkg::LK_LOAD]) |
                 (fall[pmr_pkg::LK_LOAD] & lvl[pmr_pkg::LK_SEL]);

    if (shift_mode) begin
      nxt_st.mode_sh = {lvl[pmr_pkg::LK_DATA], st_ff.mode_sh[pmr_pkg::MODE_W-1:1]};
    end
    // holding buffer moves only on the strobe fall, so outputs never ripple
    if (fall[pmr_pkg::LK_MWR]) begin
      nxt_st.mode_buf = st_ff.mode_sh;
    end

    if (copy_store) begin
      nxt_st.staging = st_ff.store;
    end else if (shift_stage) begin
      // outgoing bit leaves at bit 0, input data fills the top
      nxt_st.staging = {lvl[pmr_pkg::LK_DATA], st_ff.staging[pmr_pkg::WORD_W-1:1]};
    end

    if (rise[pmr_pkg::LK_ERASE] & lvl[pmr_pkg::LK_SWR] & lvl[pmr_pkg::LK_SEL] &
        lvl[pmr_pkg::LK_LOAD]) begin
      nxt_st.store = pmr_pkg::STORE_RST;
    end else if (rise[pmr_pkg::LK_WRITE] & lvl[pmr_pkg::LK_SWR] & ~lvl[pmr_pkg::LK_SEL] &
                 lvl[pmr_pkg::LK_LOAD]) begin
      // all bits in one step; cells can only be cleared by a write
      nxt_st.store = st_ff.store & st_ff.staging;
    end

    // bit zero sits on the pin before the first clock edge
    if (eff[pmr_pkg::MB_READBACK]) begin
      nxt_st.dout = st_ff.staging[0];
    end else if (eff[pmr_pkg::MB_VCO] & ~pd) begin
      nxt_st.dout = divided_vco_i;
    end else if (eff[pmr_pkg::MB_MODULUS_SELECT] & ~pd) begin
      nxt_st.dout = modulus_select_i;
    end else if (eff[pmr_pkg::MB_REF] & ~pd) begin
      nxt_st.dout = divided_reference_i;
    end else begin
      nxt_st.dout = 1'b0;
    end

    nxt_st.pdown = pd;
    nxt_st.cload = eff[pmr_pkg::MB_CLOAD];
    // counters frozen while powered down; counter load makes the update continuous
    if (~pd & (eff[pmr_pkg::MB_CLOAD] | reload_i)) begin
      nxt_st.word = st_ff.staging;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{mode_sh: pmr_pkg::MODE_RST, mode_buf: pmr_pkg::MODE_RST,
                 staging: pmr_pkg::WORD_RST, store: pmr_pkg::STORE_RST,
                 word: pmr_pkg::WORD_RST, dout: 1'b0, pdown: 1'b0, cload: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.serial_out = st_ff.dout;
  assign counter_word_o = st_ff.word;
  assign counter_load_o = st_ff.cload;
  assign power_down_o = st_ff.pdown;
  assign store_o = st_ff.store;
endmodule // pmr_device

// file: design/pmr_programmer.sv
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module pmr_programmer #(
  parameter int unsigned PULSE_CYC = pmr_pkg::PULSE_CYC,
  parameter int unsigned GAP_CYC = pmr_pkg::GAP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  pmr_link_if.prog link
);
  typedef struct packed {
    pmr_pkg::pmr_host_st_t st;
    pmr_pkg::pmr_op_t op;
    logic [31:0] cnt;
    logic [4:0] slot;
    logic pass;
    logic [19:0] sh;
    logic [19:0] rd;
    logic [19:0] rd_word;
    logic [7:0] mode_r;
    logic [19:0] word_r;
    logic en_r;
    logic mode_ok;
    logic ack;
    logic [31:0] dat;
    logic sclk;
    logic sdata;
    logic swr;
    logic mwr;
    logic sel;
    logic load;
    logic men_n;
    logic erase;
    logic write;
  } pmr_host_st_ff_t;
  pmr_host_st_ff_t st_ff;
  pmr_host_st_ff_t nxt_st;

  logic dout_s;
  logic req;
  logic half_end;
  logic [4:0] last;
  logic [31:0] m;
  logic [31:0] rdata;
  pmr_pkg::pmr_op_t op_req;

  pmr_sync #(
    .W(1)
  ) u_dout_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(link.serial_out),
    .level_o(dout_s),
    .rise_o(),
    .fall_o()
  );

  always_comb begin
    nxt_st = st_ff;
    req = cyc_i & stb_i;
    m = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    half_end = st_ff.cnt == 32'(pmr_pkg::SCLK_HALF_CYC - 1);
    last = (st_ff.op == pmr_pkg::OP_MODE) ? 5'(pmr_pkg::MODE_W - 1) : 5'(pmr_pkg::WORD_W - 1);
    op_req = pmr_pkg::pmr_op_t'(dat_i[2:0]);
    rdata = 32'h00000000;
    if (adr_i == pmr_pkg::OFS_MODE) begin
      rdata = {24'h000000, st_ff.mode_r};
    end else if (adr_i == pmr_pkg::OFS_WORD) begin
      rdata = {12'h000, st_ff.word_r};
    end else if (adr_i == pmr_pkg::OFS_STATUS) begin
      rdata[pmr_pkg::ST_BUSY] = st_ff.st != pmr_pkg::HS_IDLE;
      rdata[pmr_pkg::ST_MODE_OK] = st_ff.mode_ok;
      rdata[pmr_pkg::ST_EN] = ~st_ff.men_n;
    end else if (adr_i == pmr_pkg::OFS_READBACK) begin
      rdata = {12'h000, st_ff.rd_word};
    end else if (adr_i == pmr_pkg::OFS_ENABLE) begin
      rdata = {31'h00000000, st_ff.en_r};
    end

    // enable held off until a known mode word has been loaded
    nxt_st.men_n = ~(st_ff.en_r & st_ff.mode_ok);
    nxt_st.cnt = st_ff.cnt + 32'h00000001;

    case (st_ff.st)
      pmr_pkg::HS_LO: begin
        if (half_end) begin
          nxt_st.cnt = '0;
          if (st_ff.op == pmr_pkg::OP_READBACK) begin
            // sample before the edge: bit zero is already on the pin
            nxt_st.rd = {dout_s, st_ff.rd[19:1]};
          end
          if (st_ff.op == pmr_pkg::OP_READBACK && st_ff.slot == last) begin
            // load falling with select high reloads staging from the store
            nxt_st.load = 1'b0;
            nxt_st.pass = 1'b1;
            if (st_ff.pass) begin
              nxt_st.rd_word = {dout_s, st_ff.rd[19:1]};
              nxt_st.st = pmr_pkg::HS_FINISH;
            end else begin
              nxt_st.st = pmr_pkg::HS_SETUP;
            end
          end else begin
            nxt_st.sclk = 1'b1;
            nxt_st.st = pmr_pkg::HS_HI;
          end
        end
      end
      pmr_pkg::HS_HI: begin
        if (half_end) begin
          nxt_st.cnt = '0;
          nxt_st.sclk = 1'b0;
          nxt_st.sh = {1'b0, st_ff.sh[19:1]};
          nxt_st.sdata = st_ff.sh[1];
          nxt_st.slot = st_ff.slot + 5'h01;
          nxt_st.st = (st_ff.slot == last) ? pmr_pkg::HS_FINISH : pmr_pkg::HS_LO;
        end
      end
      pmr_pkg::HS_SETUP: begin
        if (half_end) begin
          nxt_st.cnt = '0;
          if (st_ff.op == pmr_pkg::OP_READBACK) begin
            nxt_st.load = 1'b1;
            nxt_st.slot = '0;
            nxt_st.rd = '0;
            nxt_st.st = pmr_pkg::HS_LO;
          end else begin
            nxt_st.erase = st_ff.op == pmr_pkg::OP_ERASE;
            nxt_st.write = st_ff.op == pmr_pkg::OP_WRITE;
            nxt_st.st = pmr_pkg::HS_PULSE;
          end
        end
      end
      pmr_pkg::HS_PULSE: begin
        if (st_ff.cnt == PULSE_CYC - 1) begin
          nxt_st.cnt = '0;
          nxt_st.erase = 1'b0;
          nxt_st.write = 1'b0;
          nxt_st.st = pmr_pkg::HS_FINISH;
        end
      end
      pmr_pkg::HS_FINISH: begin
        if (half_end) begin
          nxt_st.cnt = '0;
          nxt_st.st = pmr_pkg::HS_IDLE;
          case (st_ff.op)
            pmr_pkg::OP_MODE: begin
              nxt_st.mwr = 1'b0;
              nxt_st.mode_ok = 1'b1;
            end
            pmr_pkg::OP_ERASE: begin
              // load stays high so the staged word survives until the write
              nxt_st.swr = 1'b0;
              nxt_st.sel = 1'b0;
              nxt_st.st = pmr_pkg::HS_GAP;
            end
            pmr_pkg::OP_WRITE: begin
              nxt_st.swr = 1'b0;
              nxt_st.load = 1'b0;
            end
            pmr_pkg::OP_READBACK: begin
              nxt_st.sel = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      pmr_pkg::HS_GAP: begin
        // relays need time to swap supplies before any write pulse
        if (st_ff.cnt == GAP_CYC - 1) begin
          nxt_st.cnt = '0;
          nxt_st.st = pmr_pkg::HS_IDLE;
        end
      end
      default: begin
        nxt_st.cnt = '0;
      end
    endcase

    nxt_st.ack = req & ~st_ff.ack;
    if (req & ~st_ff.ack) begin
      nxt_st.dat = rdata;
    end
    if (req & st_ff.ack & we_i) begin
      if (adr_i == pmr_pkg::OFS_MODE) begin
        nxt_st.mode_r = (st_ff.mode_r & ~m[7:0]) | (dat_i[7:0] & m[7:0]);
      end else if (adr_i == pmr_pkg::OFS_WORD) begin
        nxt_st.word_r = (st_ff.word_r & ~m[19:0]) | (dat_i[19:0] & m[19:0]);
      end else if (adr_i == pmr_pkg::OFS_ENABLE && sel_i[0]) begin
        nxt_st.en_r = dat_i[0];
      end else if (adr_i == pmr_pkg::OFS_CMD && sel_i[0] && st_ff.st == pmr_pkg::HS_IDLE) begin
        nxt_st.op = op_req;
        nxt_st.cnt = '0;
        nxt_st.slot = '0;
        nxt_st.pass = 1'b0;
        case (op_req)
          pmr_pkg::OP_MODE: begin
            nxt_st.mwr = 1'b1;
            nxt_st.load = 1'b0;
            nxt_st.sel = 1'b0;
            nxt_st.sh = {12'h000, st_ff.mode_r};
            nxt_st.sdata = st_ff.mode_r[0];
            nxt_st.st = pmr_pkg::HS_LO;
          end
          pmr_pkg::OP_WORD: begin
            nxt_st.load = 1'b1;
            nxt_st.sel = 1'b0;
            nxt_st.sh = st_ff.word_r;
            nxt_st.sdata = st_ff.word_r[0];
            nxt_st.st = pmr_pkg::HS_LO;
          end
          pmr_pkg::OP_ERASE: begin
            nxt_st.swr = 1'b1;
            nxt_st.sel = 1'b1;
            nxt_st.load = 1'b1;
            nxt_st.st = pmr_pkg::HS_SETUP;
          end
          pmr_pkg::OP_WRITE: begin
            nxt_st.swr = 1'b1;
            nxt_st.sel = 1'b0;
            nxt_st.load = 1'b1;
            nxt_st.st = pmr_pkg::HS_SETUP;
          end
          pmr_pkg::OP_READBACK: begin
            // refused unless the enable line is already low
            if (~st_ff.men_n) begin
              nxt_st.sel = 1'b1;
              nxt_st.load = 1'b1;
              nxt_st.sh = '0;
              nxt_st.sdata = 1'b0;
              nxt_st.st = pmr_pkg::HS_SETUP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.men_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dat_o = st_ff.dat;
  assign ack_o = st_ff.ack;
  assign link.ser_clk = st_ff.sclk;
  assign link.ser_data = st_ff.sdata;
  assign link.sec_wr = st_ff.swr;
  assign link.mode_wr = st_ff.mwr;
  assign link.store_select = st_ff.sel;
  assign link.store_load = st_ff.load;
  assign link.mode_enable_n = st_ff.men_n;
  assign link.erase_pulse = st_ff.erase;
  assign link.write_pulse = st_ff.write;
endmodule // pmr_programmer

// file: dv/pmr_assertions.sv
`timescale 1ns/1ps
module pmr_assertions #(
  parameter int unsigned PULSE_CYC = 20,
  parameter int unsigned GAP_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic sec_wr,
  input wire logic mode_wr,
  input wire logic store_select,
  input wire logic store_load,
  input wire logic mode_enable_n,
  input wire logic erase_pulse,
  input wire logic write_pulse,
  input wire logic serial_out
);
  logic [31:0] pulse_cnt_ff;
  logic [31:0] gap_cnt_ff;
  logic mode_seen_ff;
  // gap counter starts saturated so a write with no erase since reset is not flagged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt_ff <= '0;
      gap_cnt_ff <= 32'hffffffff;
      mode_seen_ff <= 1'b0;
    end else begin
      pulse_cnt_ff <= (erase_pulse || write_pulse) ? pulse_cnt_ff + 32'h1 : '0;
      if (erase_pulse) gap_cnt_ff <= '0;
      else if (gap_cnt_ff != 32'hffffffff) gap_cnt_ff <= gap_cnt_ff + 32'h1;
      if ($fell(mode_wr) && !store_load) mode_seen_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_erase_setup; erase_pulse |-> sec_wr && store_select && store_load; endproperty
  a_erase_setup: assert property (p_erase_setup)
    else $error("erase pulse without its control lines");
  property p_write_setup; write_pulse |-> sec_wr && !store_select && store_load; endproperty
  a_write_setup: assert property (p_write_setup)
    else $error("write pulse without its control lines");
  property p_pulse_len; $fell(erase_pulse || write_pulse) |-> pulse_cnt_ff == PULSE_CYC; endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("programming pulse length wrong");
  property p_gap; $rose(write_pulse) |-> gap_cnt_ff >= GAP_CYC; endproperty
  a_gap: assert property (p_gap)
    else $error("erase to write gap too short");
  property p_no_overlap; !(erase_pulse && write_pulse); endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both pulses at once");
  property p_data_stable; $rose(ser_clk) |-> $stable(ser_data); endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("serial data moved at clock rise");
  property p_enable_late; !mode_enable_n |-> mode_seen_ff; endproperty
  a_enable_late: assert property (p_enable_late)
    else $error("mode enable low before mode load");
  property p_idle_out; mode_enable_n [*8] |-> !serial_out; endproperty
  a_idle_out: assert property (p_idle_out)
    else $error("serial output active while disabled");
  property p_load_drop; $fell(write_pulse) |-> ##[1:40] !store_load; endproperty
  a_load_drop: assert property (p_load_drop)
    else $error("store load not dropped after write");
  property p_load_steady; $rose(write_pulse) |-> $past(store_load, 8) && store_load; endproperty
  a_load_steady: assert property (p_load_steady)
    else $error("store load toggled before write");
  c_erase: cover property ($rose(erase_pulse));
  c_write: cover property ($rose(write_pulse));
  c_readback: cover property ($fell(store_load) && store_select);
  c_mode: cover property ($fell(mode_wr));
endmodule // pmr_assertions

// file: dv/test_pll_mode_reg_and_eeprom_prog.sv
`timescale 1ns/1ps
module test_pll_mode_reg_and_eeprom_prog;
  localparam int unsigned PULSE = 20;
  localparam int unsigned GAP = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [31:0] rdat;
  logic [2:0] src = 3'h0;
  logic reload = 1'b0;
  logic [19:0] cword;
  logic [19:0] store;
  logic cload;
  logic pdown;
  int num_errors = 0;
  int tests_run = 0;
  always #12.5 clk_i = ~clk_i;
  pmr_link_if lk();
  pmr_programmer #(.PULSE_CYC(PULSE), .GAP_CYC(GAP)) pmr_programmer_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .link(lk));
  pmr_device pmr_device_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(lk), .divided_vco_i(src[0]),
    .modulus_select_i(src[1]), .divided_reference_i(src[2]), .reload_i(reload),
    .counter_word_o(cword), .counter_load_o(cload), .power_down_o(pdown), .store_o(store));
  pmr_assertions #(.PULSE_CYC(PULSE), .GAP_CYC(GAP)) pmr_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .ser_clk(lk.ser_clk), .ser_data(lk.ser_data),
    .sec_wr(lk.sec_wr), .mode_wr(lk.mode_wr), .store_select(lk.store_select),
    .store_load(lk.store_load), .mode_enable_n(lk.mode_enable_n),
    .erase_pulse(lk.erase_pulse), .write_pulse(lk.write_pulse), .serial_out(lk.serial_out));
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    tests_run++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    rdat = dat_o;
    if (n >= 100) chk(32'h0, 32'h1, "ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmd(input pmr_pkg::pmr_op_t op);
    int n;
    wb(1'b1, pmr_pkg::OFS_CMD, 32'(op));
    n = 0;
    do begin
      wb(1'b0, pmr_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rdat[pmr_pkg::ST_BUSY] !== 1'b0 && n < 3000);
    chk({31'h0, rdat[pmr_pkg::ST_BUSY]}, 32'h0, "busy clear");
  endtask
  task automatic mode(input logic [7:0] m);
    wb(1'b1, pmr_pkg::OFS_MODE, {24'h0, m});
    cmd(pmr_pkg::OP_MODE);
  endtask
  task automatic word(input logic [19:0] v);
    wb(1'b1, pmr_pkg::OFS_WORD, {12'h0, v});
    cmd(pmr_pkg::OP_WORD);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask
  initial begin
    #(25.0 * 60000);
    chk(32'h0, 32'h1, "watchdog");
    summarize();
  end
  initial begin
    logic [7:0] route [3];
    route = '{8'h04, 8'h20, 8'h40};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, pmr_pkg::OFS_MODE, 32'h0);
    chk(rdat, 32'h0, "mode reset");
    wb(1'b0, pmr_pkg::OFS_STATUS, 32'h0);
    chk(rdat, 32'h0, "status reset");
    wb(1'b0, 8'h1c, 32'h0);
    chk(rdat, 32'h0, "unmapped read");
    chk({31'h0, lk.mode_enable_n}, 32'h1, "enable idle");
    chk({12'h0, store}, {12'h0, pmr_pkg::STORE_RST}, "store reset");
    word(20'h5a3c1);
    chk({12'h0, cword}, 32'h0, "counter held");
    @(posedge clk_i) reload <= 1'b1;
    @(posedge clk_i) reload <= 1'b0;
    settle();
    chk({12'h0, cword}, 32'h0005a3c1, "counter reload");
    cmd(pmr_pkg::OP_ERASE);
    chk({12'h0, store}, 32'h000fffff, "erased store");
    cmd(pmr_pkg::OP_WRITE);
    chk({12'h0, store}, 32'h0005a3c1, "written store");
    word(20'h0ffff);
    cmd(pmr_pkg::OP_WRITE);
    chk({12'h0, store}, 32'h0000a3c1, "and on write");
    cmd(pmr_pkg::OP_READBACK);
    wb(1'b0, pmr_pkg::OFS_READBACK, 32'h0);
    chk(rdat, 32'h0, "readback refused");
    mode(8'h02);
    wb(1'b1, pmr_pkg::OFS_ENABLE, 32'h1);
    settle();
    chk({31'h0, lk.mode_enable_n}, 32'h0, "enable low");
    cmd(pmr_pkg::OP_READBACK);
    wb(1'b0, pmr_pkg::OFS_READBACK, 32'h0);
    chk(rdat, 32'h0000a3c1, "readback word");
    for (int i = 0; i < 3; i++) begin
      mode(route[i]);
      @(posedge clk_i) src <= 3'h1 << i;
      settle();
      chk({31'h0, lk.serial_out}, 32'h1, "routed high");
      @(posedge clk_i) src <= ~(3'h1 << i);
      settle();
      chk({31'h0, lk.serial_out}, 32'h0, "routed low");
    end
    @(posedge clk_i) src <= 3'h7;
    wb(1'b1, pmr_pkg::OFS_ENABLE, 32'h0);
    settle();
    chk({31'h0, lk.serial_out}, 32'h0, "disabled out");
    wb(1'b1, pmr_pkg::OFS_ENABLE, 32'h1);
    mode(8'h0c);
    settle();
    chk({31'h0, pdown}, 32'h1, "power down");
    chk({31'h0, lk.serial_out}, 32'h0, "blanked out");
    wb(1'b1, pmr_pkg::OFS_ENABLE, 32'h0);
    mode(8'h10);
    settle();
    chk({31'h0, cload}, 32'h0, "load gated");
    wb(1'b1, pmr_pkg::OFS_ENABLE, 32'h1);
    settle();
    chk({31'h0, cload}, 32'h1, "load active");
    chk({31'h0, pdown}, 32'h0, "power up");
    word(20'h12345);
    settle();
    chk({12'h0, cword}, 32'h00012345, "counter word");
    wb(1'b1, pmr_pkg::OFS_MODE, 32'h0);
    wb(1'b1, pmr_pkg::OFS_CMD, 32'(pmr_pkg::OP_MODE));
    // part way through the shift the old buffered mode must still rule
    repeat (100) @(posedge clk_i);
    chk({31'h0, cload}, 32'h1, "mode held while shifting");
    cmd(pmr_pkg::OP_NONE);
    settle();
    chk({31'h0, cload}, 32'h0, "mode applied");
    summarize();
  end
endmodule // test_pll_mode_reg_and_eeprom_prog
